// ---- core/host_spi_port_config.sv ----
// serial peripheral port with six shared pins, wishbone registers and interrupt
// Notes on behaviour
// - reset clears port data and leaves all six pins as inputs
// - setting serial system enable gives the pins to the serial function
// - serial pins: 5 select, 4 clock, 3 mosi, 2 miso, 1 txd, 0 rxd
// - port data upper two bits unused; writes to them ignored
// - direction bit zero makes pin input, one makes it output
// - direction register upper two bits ignore writes and touch no pin
// - serial master forces select, miso and rxd pins to inputs
// - serial master drives clock, mosi, txd only when their direction bits set
// - interrupt enable clear means no interrupt request at all
// - interrupt enable set requests interrupt on transfer complete, mode fault or write collision, each gated by its mask bit
// - clearing serial system enable returns pins to plain general purpose use
// - wired-or mode makes all outputs open drain, else push-pull
// - serial clock idles at the polarity bit level
// - rate codes 00..11 divide the clock by 2, 4, 16, 32
// - transfer done sets complete flag; flags read then buffer access clears it
// - as master, buffer write starts a transfer; results go to flag register
// - master with select pin low sets the mode fault flag
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module host_spi_port_config
	import spi_port_pkg::*;
(
	input  wire logic              clk_i,       // 40 MHz clock
	input  wire logic              rst_i,       // synchronous reset, active high
	input  wire logic              wb_cyc_i,    // bus cycle
	input  wire logic              wb_stb_i,    // bus strobe
	input  wire logic              wb_we_i,     // bus write
	input  wire logic [ADDR_W-1:0] wb_adr_i,    // byte address
	input  wire logic [3:0]        wb_sel_i,    // byte lanes
	input  wire logic [31:0]       wb_dat_i,    // write data
	output logic      [31:0]       wb_dat_o,    // read data
	output logic                   wb_ack_o,    // bus acknowledge
	input  wire logic [PORT_W-1:0] pin_i,       // pin levels
	output logic      [PORT_W-1:0] pin_o,       // pin output values
	output logic      [PORT_W-1:0] pin_oe_n_o,  // low while pin driven
	output logic                   irq_o        // interrupt request level
);
	logic              ack;
	logic [31:0]       rdata;
	logic [PORT_W-1:0] port_data;
	logic [PORT_W-1:0] port_dir;
	control_t          ctrl;
	logic [2:0]        irq_stat;
	logic [2:0]        irq_mask;
	xfer_state_t       state;
	logic [4:0]        div_cnt;
	logic [4:0]        half;
	logic [3:0]        edge_cnt;
	logic              sck_phase;
	logic [7:0]        shreg;
	logic [7:0]        rx_buf;
	logic              rx_bit;
	logic              mosi_q;
	logic              tc;
	logic              wcol;
	logic              mode_fault_flag;
	logic              arm_tc;
	logic              arm_mode_fault_flag;
	logic [PORT_W-1:0] drive;
	logic [PORT_W-1:0] out_val;
	logic [7:0]        next_shreg;

	wire logic req      = wb_cyc_i & wb_stb_i & ~ack;
	wire logic wr       = req & wb_we_i & wb_sel_i[0];
	wire logic rd       = req & ~wb_we_i;
	wire logic hit_data = (wb_adr_i == ADR_PORT_DATA);
	wire logic hit_dir  = (wb_adr_i == ADR_PORT_DIR);
	wire logic hit_ctrl = (wb_adr_i == ADR_CONTROL);
	wire logic hit_flg  = (wb_adr_i == ADR_FLAGS);
	wire logic hit_buf  = (wb_adr_i == ADR_SHIFT_BUF);
	wire logic hit_ist  = (wb_adr_i == ADR_IRQ_STAT);
	wire logic hit_imk  = (wb_adr_i == ADR_IRQ_MASK);
	wire logic serial   = ctrl.serial_system_enable;
	wire logic master   = serial & ctrl.master_select;
	wire logic busy     = (state == ST_SHIFT);
	wire logic fault    = master & ~pin_i[PIN_SS];
	wire logic start    = wr & hit_buf & master & ~busy & ~fault;
	wire logic collide  = wr & hit_buf & busy;
	wire logic tick     = busy & (div_cnt == half - 5'h01);
	wire logic leading  = ~edge_cnt[0];
	wire logic done     = tick & (edge_cnt == 4'(XFER_EDGES - 5'h01));
	wire logic abort    = busy & (~master | fault);
	wire logic buf_acc  = req & hit_buf;
	wire logic sck_lvl  = ctrl.clock_polarity_bit ^ sck_phase;
	wire logic [2:0] ev = {collide, fault, done};

	// bus slave: one wait state, every address answers, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			rdata <= 32'h0000_0000;
			case (1'b1)
				hit_data: rdata[PORT_W-1:0] <= (drive & out_val) | (~drive & pin_i);
				hit_dir:  rdata[PORT_W-1:0] <= port_dir;
				hit_ctrl: rdata[7:0] <= ctrl;
				hit_flg:  rdata[7:0] <= {tc, wcol, 1'b0, mode_fault_flag, 4'h0};
				hit_buf:  rdata[7:0] <= rx_buf;
				hit_ist:  rdata[2:0] <= irq_stat;
				hit_imk:  rdata[2:0] <= irq_mask;
				default:  rdata <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;

	// only six bits are stored, so upper-bit writes vanish
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_data <= PORT_DATA_RST;
		end else if (wr & hit_data) begin
			port_data <= wb_dat_i[PORT_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_dir <= PORT_DIR_RST;
		end else if (wr & hit_dir) begin
			port_dir <= wb_dat_i[PORT_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= CONTROL_RST;
		end else if (wr & hit_ctrl) begin
			ctrl <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask <= IRQ_MASK_RST;
		end else if (wr & hit_imk) begin
			irq_mask <= wb_dat_i[2:0];
		end
	end

	// write-one-to-clear; a new event in the clearing cycle survives
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= 3'h0;
		end else begin
			irq_stat <= (irq_stat & ~((wr & hit_ist) ? wb_dat_i[2:0] : 3'h0)) | ev;
		end
	end

	assign irq_o = ctrl.serial_interrupt_enable & |(irq_stat & irq_mask);

	// clear sequence: flag read arms, later buffer access (or control write) clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arm_tc <= 1'b0;
		end else if (rd & hit_flg & (tc | wcol)) begin
			arm_tc <= 1'b1;
		end else if (buf_acc) begin
			arm_tc <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arm_mode_fault_flag <= 1'b0;
		end else if (rd & hit_flg & mode_fault_flag) begin
			arm_mode_fault_flag <= 1'b1;
		end else if (wr & hit_ctrl) begin
			arm_mode_fault_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tc <= 1'b0;
		end else if (done) begin
			tc <= 1'b1;
		end else if (buf_acc & arm_tc) begin
			tc <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wcol <= 1'b0;
		end else if (collide) begin
			wcol <= 1'b1;
		end else if (buf_acc & arm_tc) begin
			wcol <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_fault_flag <= 1'b0;
		end else if (fault) begin
			mode_fault_flag <= 1'b1;
		end else if (wr & hit_ctrl & arm_mode_fault_flag) begin
			mode_fault_flag <= 1'b0;
		end
	end

	always_comb begin
		case (ctrl.bit_rate_select)
			2'b00:   half = HALF_CODE0;
			2'b01:   half = HALF_CODE1;
			2'b10:   half = HALF_CODE2;
			default: half = HALF_CODE3;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE:  state <= start ? ST_SHIFT : ST_IDLE;
				ST_SHIFT: state <= (done | abort) ? ST_IDLE : ST_SHIFT;
				default:  state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i | start | tick) begin
			div_cnt <= 5'h00;
		end else if (busy) begin
			div_cnt <= div_cnt + 5'h01;
		end
	end

	// sixteen clock edges per byte; phase returns to idle after the last one
	always_ff @(posedge clk_i) begin
		if (rst_i | start | abort) begin
			edge_cnt  <= 4'h0;
			sck_phase <= 1'b0;
		end else if (tick) begin
			edge_cnt  <= edge_cnt + 4'h1;
			sck_phase <= ~sck_phase;
		end
	end

	always_comb begin
		next_shreg = ctrl.clock_phase_bit ? {shreg[6:0], pin_i[PIN_MISO]} : {shreg[6:0], rx_bit};
	end

	// phase 0: launch before first edge, sample leading, shift trailing
	// phase 1: launch on leading, sample and shift on trailing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shreg  <= 8'h00;
			rx_bit <= 1'b0;
			mosi_q <= 1'b0;
		end else if (start) begin
			shreg <= wb_dat_i[7:0];
			if (!ctrl.clock_phase_bit) begin
				mosi_q <= wb_dat_i[7];
			end
		end else if (tick & leading) begin
			if (ctrl.clock_phase_bit) begin
				mosi_q <= shreg[7];
			end else begin
				rx_bit <= pin_i[PIN_MISO];
			end
		end else if (tick) begin
			shreg <= next_shreg;
			if (!ctrl.clock_phase_bit) begin
				mosi_q <= shreg[6];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_buf <= 8'h00;
		end else if (done) begin
			rx_buf <= next_shreg;
		end
	end

	// pin steering; slave mode only frees the select, clock and mosi pins
	always_comb begin
		out_val = port_data;
		drive   = port_dir;
		if (master) begin
			drive[PIN_SS]     = 1'b0;
			drive[PIN_MISO]   = 1'b0;
			drive[PIN_RXD]    = 1'b0;
			out_val[PIN_SCK]  = sck_lvl;
			out_val[PIN_MOSI] = mosi_q;
		end else if (serial) begin
			drive[PIN_SS]   = 1'b0;
			drive[PIN_SCK]  = 1'b0;
			drive[PIN_MOSI] = 1'b0;
		end
	end

	// open drain only pulls low; a high level is left to the pull-up
	assign pin_o      = out_val;
	assign pin_oe_n_o = ~(drive & (~{PORT_W{ctrl.wired_or_mode}} | ~out_val));

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	reset_pins_a: assert property ($past(rst_i) |-> pin_oe_n_o == 6'h3f && port_data == 6'h00)
		else $error("pins not released after reset");
	sck_map_a: assert property (master && port_dir[PIN_SCK] && !ctrl.wired_or_mode
		|-> !pin_oe_n_o[PIN_SCK] && pin_o[PIN_SCK] == sck_lvl)
		else $error("serial clock not on its pin");
	data_upper_a: assert property (rd && hit_data |=> wb_dat_o[31:PORT_W] == 26'h0)
		else $error("port data upper bits not zero");
	dir_upper_a: assert property (rd && hit_dir |=> wb_dat_o[31:PORT_W] == 26'h0)
		else $error("direction upper bits not zero");
	gpio_input_a: assert property (!serial |-> &(pin_oe_n_o | port_dir))
		else $error("input pin driven");
	master_inputs_a: assert property (master |-> pin_oe_n_o[PIN_SS] && pin_oe_n_o[PIN_MISO] && pin_oe_n_o[PIN_RXD])
		else $error("master input pin driven");
	out_needs_dir_a: assert property (master && !port_dir[PIN_MOSI] |-> pin_oe_n_o[PIN_MOSI])
		else $error("mosi driven without direction bit");
	irq_off_a: assert property (!ctrl.serial_interrupt_enable |-> !irq_o)
		else $error("interrupt while disabled");
	irq_on_a: assert property (done && ctrl.serial_interrupt_enable && irq_mask[IRQ_TC] |=> irq_o)
		else $error("no interrupt after transfer");
	open_drain_a: assert property (ctrl.wired_or_mode |-> !(|(~pin_oe_n_o & pin_o)))
		else $error("open drain pin driven high");
	idle_pol_a: assert property (!busy |-> sck_lvl == ctrl.clock_polarity_bit)
		else $error("serial clock idles at wrong level");
	rate_div2_a: assert property (start && ctrl.bit_rate_select == 2'b00 |-> ##16 done)
		else $error("divide by two transfer length wrong");
	rate_div4_a: assert property (start && ctrl.bit_rate_select == 2'b01 |-> ##32 done)
		else $error("divide by four transfer length wrong");
	tc_set_a: assert property (done |=> tc && rx_buf == $past(next_shreg))
		else $error("complete flag not set");
	start_busy_a: assert property (start |=> busy ##0 mosi_q == ($past(ctrl.clock_phase_bit) ? 1'b0 : $past(wb_dat_i[7])) || $past(ctrl.clock_phase_bit))
		else $error("transfer not started");
	mode_fault_flag_a: assert property (fault |=> mode_fault_flag)
		else $error("mode fault not flagged");

	full_xfer_c: cover property (start ##[1:600] done);
	fault_c: cover property (busy && fault);
	clear_c: cover property (rd && hit_flg && tc ##[1:20] buf_acc && arm_tc);
	collide_c: cover property (collide);
endmodule

// ---- core/spi_port_pkg.sv ----
// shared constants and carriers for the serial peripheral port block
package spi_port_pkg;
	localparam int          ADDR_W        = 16;
	localparam int          PORT_W        = 6;
	localparam int          XFER_BITS     = 8;
	localparam logic [4:0]  XFER_EDGES    = 5'h10;
	// register byte addresses on the bus
	localparam logic [15:0] ADR_PORT_DATA = 16'h1008;
	localparam logic [15:0] ADR_PORT_DIR  = 16'h100c;
	localparam logic [15:0] ADR_CONTROL   = 16'h1010;
	localparam logic [15:0] ADR_FLAGS     = 16'h1014;
	localparam logic [15:0] ADR_SHIFT_BUF = 16'h1018;
	localparam logic [15:0] ADR_IRQ_STAT  = 16'h101c;
	localparam logic [15:0] ADR_IRQ_MASK  = 16'h1020;
	// reset values
	localparam logic [5:0]  PORT_DATA_RST = 6'h00;
	localparam logic [5:0]  PORT_DIR_RST  = 6'h00;
	localparam logic [7:0]  CONTROL_RST   = 8'h04;
	localparam logic [2:0]  IRQ_MASK_RST  = 3'h7;
	// pin positions in serial mode
	localparam int          PIN_SS        = 5;
	localparam int          PIN_SCK       = 4;
	localparam int          PIN_MOSI      = 3;
	localparam int          PIN_MISO      = 2;
	localparam int          PIN_TXD       = 1;
	localparam int          PIN_RXD       = 0;
	// flag register bit positions
	localparam int          FLG_TC        = 7;
	localparam int          FLG_WCOL      = 6;
	localparam int          FLG_MODE_FAULT_FLAG      = 4;
	// interrupt status bit positions
	localparam int          IRQ_TC        = 0;
	localparam int          IRQ_MODE_FAULT_FLAG      = 1;
	localparam int          IRQ_WCOL      = 2;
	// clock dividers for rate codes 00..11, and half periods in clk_i cycles
	localparam int          DIV_CODE0     = 2;
	localparam int          DIV_CODE1     = 4;
	localparam int          DIV_CODE2     = 16;
	localparam int          DIV_CODE3     = 32;
	localparam logic [4:0]  HALF_CODE0    = 5'(DIV_CODE0 / 2);
	localparam logic [4:0]  HALF_CODE1    = 5'(DIV_CODE1 / 2);
	localparam logic [4:0]  HALF_CODE2    = 5'(DIV_CODE2 / 2);
	localparam logic [4:0]  HALF_CODE3    = 5'(DIV_CODE3 / 2);

	typedef struct packed {
		logic       serial_interrupt_enable;
		logic       serial_system_enable;
		logic       wired_or_mode;
		logic       master_select;
		logic       clock_polarity_bit;
		logic       clock_phase_bit;
		logic [1:0] bit_rate_select;
	} control_t;

	typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;
endpackage

// ---- dv/dac_slave_model.sv ----
// behavioural serial dac: collects command bits and rotates a reply word out
`timescale 1ns/1ps
module dac_slave_model (
	input  wire logic        sck_i,         // serial clock level
	input  wire logic        mosi_i,        // command data in
	input  wire logic        cs_n_i,        // chip select, low selects
	input  wire logic        sample_rise_i, // sample on rising clock edge
	output logic             miso_o,        // reply data out
	output logic      [15:0] word_o         // bits taken, msb first
);
	logic [15:0] reply = 16'hc35a;
	initial word_o = 16'h0000;
	// a released line shows the inverse bit so a stale value cannot pass
	assign miso_o = cs_n_i ? ~reply[15] : reply[15];
	// each frame starts from the same reply, so pin glitches before a frame do not skew it
	always @(posedge cs_n_i) reply <= 16'hc35a;
	always @(posedge sck_i) begin
		if (!cs_n_i && sample_rise_i) word_o <= {word_o[14:0], mosi_i};
		if (!cs_n_i && !sample_rise_i) reply <= {reply[14:0], reply[15]};
	end
	always @(negedge sck_i) begin
		if (!cs_n_i && !sample_rise_i) word_o <= {word_o[14:0], mosi_i};
		if (!cs_n_i && sample_rise_i) reply <= {reply[14:0], reply[15]};
	end
endmodule

// ---- dv/host_spi_port_config_test.sv ----
// self-checking bench: registers, pin muxing, transfers, interrupts, mode fault
`timescale 1ns/1ps
module host_spi_port_config_test;
	import spi_port_pkg::*;
	logic              clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic              ss_lvl = 1'b1, samp_rise = 1'b1, idle = 1'b0, wb_ack_o, irq_o, miso;
	logic [ADDR_W-1:0] wb_adr_i = 16'h0000;
	logic [3:0]        wb_sel_i = 4'h0;
	logic [31:0]       wb_dat_i = 32'h0, wb_dat_o;
	logic [PORT_W-1:0] pin_i, pin_o, pin_oe_n_o;
	logic [15:0]       slave_word;
	logic [7:0]        q;
	int                num_errors = 0, cmp_count = 0, act_cnt = 0;
	always #12.5 clk_i = ~clk_i;
	// undriven pins sit on pull-ups, except select and the dac reply line
	assign pin_i = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & {ss_lvl, 2'b11, miso, 2'b11});
	always @(posedge clk_i) if (pin_i[4] !== idle) act_cnt <= act_cnt + 1;
	host_spi_port_config u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_i, .pin_o, .pin_oe_n_o, .irq_o);
	dac_slave_model u_dac (.sck_i(pin_i[4]), .mosi_i(pin_i[3]), .cs_n_i(pin_i[1]),
		.sample_rise_i(samp_rise), .miso_o(miso), .word_o(slave_word));
	task automatic summarize();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			chk("bus ack", 1, 0);
			summarize();
		end
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
		bus(1'b0, a, 8'h00);
		chk(what, exp, q);
	endtask
	task automatic xfer(input logic [1:0] m, input logic [7:0] tx);
		int n, dv;
		dv = (m == 2'h0) ? DIV_CODE0 : (m == 2'h1) ? DIV_CODE1 : (m == 2'h2) ? DIV_CODE2 : DIV_CODE3;
		samp_rise <= (m[0] == m[1]);
		idle <= m[0];
		wr(ADR_CONTROL, {4'hd, m[0], m[1], m});
		chk("sck idle", m[0], pin_o[4]);
		act_cnt = 0;
		wr(ADR_SHIFT_BUF, tx);
		n = 0;
		do begin
			bus(1'b0, ADR_FLAGS, 8'h00);
			n++;
		end while (q[7] !== 1'b1 && n < 200);
		chk("complete flag", 1, q[7]);
		chk("sck active cycles", 4 * dv, act_cnt);
		chk("sck idle after", m[0], pin_o[4]);
		chk("dac byte", tx, slave_word[7:0]);
		bus(1'b0, ADR_SHIFT_BUF, 8'h00);
		if (m == 2'h0) chk("rx byte", 8'hc3, q);
		rd(ADR_FLAGS, 8'h00, "flags cleared");
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("oe after reset", 6'h3f, pin_oe_n_o);
		rd(ADR_CONTROL, CONTROL_RST, "control reset");
		rd(ADR_IRQ_MASK, 8'h07, "mask reset");
		wr(ADR_PORT_DIR, 8'hff);
		rd(ADR_PORT_DIR, 8'h3f, "direction upper bits");
		rd(ADR_PORT_DATA, 8'h00, "data after reset");
		wr(ADR_PORT_DATA, 8'hea);
		rd(ADR_PORT_DATA, 8'h2a, "data upper bits");
		chk("pin out", 6'h2a, pin_o);
		chk("oe all out", 6'h00, pin_oe_n_o);
		wr(ADR_CONTROL, 8'h24);
		chk("open drain oe", 6'h2a, pin_oe_n_o);
		wr(ADR_PORT_DIR, 8'h0f);
		chk("open drain mixed", 6'h3a, pin_oe_n_o);
		wr(ADR_CONTROL, 8'h04);
		chk("push pull oe", 6'h30, pin_oe_n_o);
		wr(ADR_PORT_DIR, 8'h3f);
		wr(ADR_PORT_DATA, 8'h02);
		wr(ADR_CONTROL, 8'hd4);
		chk("serial master oe", 6'h25, pin_oe_n_o);
		wr(ADR_PORT_DATA, 8'h00);
		for (int m = 0; m < 4; m++) xfer(2'(m), 8'h96 ^ 8'(m * 37));
		chk("irq on done", 1, irq_o);
		rd(ADR_IRQ_STAT, 8'h01, "irq status");
		wr(ADR_IRQ_MASK, 8'h00);
		chk("irq masked", 0, irq_o);
		wr(ADR_IRQ_MASK, 8'h07);
		wr(ADR_CONTROL, 8'h54);
		chk("irq disabled", 0, irq_o);
		wr(ADR_IRQ_STAT, 8'h01);
		rd(ADR_IRQ_STAT, 8'h00, "irq cleared");
		wr(ADR_PORT_DIR, 8'h00);
		chk("outputs need dir", 6'h3f, pin_oe_n_o);
		wr(ADR_PORT_DIR, 8'h3f);
		ss_lvl <= 1'b0;
		repeat (3) @(posedge clk_i);
		bus(1'b0, ADR_FLAGS, 8'h00);
		chk("mode fault", 8'h10, q & 8'h10);
		ss_lvl <= 1'b1;
		repeat (3) @(posedge clk_i);
		bus(1'b0, ADR_FLAGS, 8'h00);
		wr(ADR_CONTROL, 8'hd4);
		rd(ADR_FLAGS, 8'h00, "mode fault cleared");
		chk("irq on fault", 1, irq_o);
		wr(ADR_CONTROL, 8'h04);
		wr(ADR_PORT_DATA, 8'h10);
		chk("gpio again", 6'h10, pin_o);
		chk("gpio oe", 6'h00, pin_oe_n_o);
		rd(16'h1030, 8'h00, "unmapped read");
		summarize();
	end
endmodule
